/* File: pkg/shift_pkg.sv */
// shared constants and types for the shift count / autopush / autopull block
package shift_pkg;

    // ************************************************************
    // register map (byte addresses, one aligned word each)
    // ************************************************************
    localparam logic [11:0] cfg_off = 12'h000;
    localparam logic [11:0] status_off = 12'h004;
    localparam logic [11:0] osr_off = 12'h008;
    localparam logic [11:0] isr_off = 12'h00c;

    // cfg fields
    localparam int pull_en_bit = 0;
    localparam int push_en_bit = 1;
    localparam int out_right_bit = 2;
    localparam int in_right_bit = 3;
    localparam int pull_th_lsb = 8;
    localparam int push_th_lsb = 16;
    localparam int th_width = 5;

    // status fields
    localparam int osr_cnt_lsb = 0;
    localparam int isr_cnt_lsb = 8;
    localparam int stall_bit = 16;

    // ************************************************************
    // reset values and counter limits
    // ************************************************************
    localparam logic [5:0] isr_cnt_rst = 6'h00;
    localparam logic [5:0] osr_cnt_rst = 6'h20;
    localparam logic [5:0] cnt_max = 6'h20;
    localparam logic [4:0] th_rst = 5'h00;
    localparam logic cfg_bit_rst = 1'b0;
    localparam logic shift_right_rst = 1'b1;

    // ************************************************************
    // operations presented by the instruction decoder
    // ************************************************************
    typedef enum logic [6:0] {
        op_other = 7'h01,
        op_out = 7'h02,
        op_in = 7'h04,
        op_pull = 7'h08,
        op_push = 7'h10,
        op_mov_osr = 7'h20,
        op_mov_isr = 7'h40
    } op_t;

endpackage

/* File: core/shift_count_autopush_autopull.sv */
// shift counters, automatic refill of the output shift register and drain of the input one
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

//Contract
//[R1] two independent saturating 6-bit counters track shifts out and in
//[R2] reset or restart strobe sets input count 0, output count 32
//[R3] OUT adds its bit count to output count, saturating
//[R4] IN adds its bit count to input count, saturating
//[R5] explicit or automatic pull zeroes the output count
//[R6] explicit or automatic push zeroes the input count
//[R7] MOV into a shift register zeroes that register's count
//[R8] OUT into the input shift register loads input count with n
//[R9] every OUT or IN compares counts with the thresholds
//[R10] autopull and autopush each act only when separately enabled
//[R11] OUT reaching pull threshold refills from TX FIFO same cycle if available
//[R12] IN reaching push threshold writes result to RX FIFO, clears register
//[R13] IN shifts, counts, then stalls on full RX FIFO or pushes and zeroes; here a stalled IN commits nothing and repeats
//[R14] shift, count and autopush of IN finish in one cycle unless stalled
//[R15] thresholds run 1 to 32; field value 0 means 32
//[R16] OUT with empty register and empty TX FIFO stalls until loaded
//[R17] pull-if-empty judges emptiness by the pull threshold
//[R18] side-set still happens on stalled cycles
//[R19] explicit PULL moves exactly one word into the output register
//[R20] stalled OUT runs the cycle after loading; 32/32 refills again
//[R21] IN filling to push threshold passes data at once, register empty
//[R22] without OUT, autopull still fires when count reaches threshold and data waits
//[R23] never load an empty register and shift it in the same cycle
//[R24] with autopull, PULL on a full register is a no-op, else stalls
//[R25] threshold checks use the count after adding the bit count
module shift_count_autopush_autopull (
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    // state machine control
    input wire logic sm_clk_en,
    input wire logic sm_restart_strobe,
    input wire logic instr_valid,
    input wire shift_pkg::op_t instr_op,
    input wire logic [4:0] bit_count,
    input wire logic out_to_isr,
    input wire logic cond_flag,
    input wire logic block_flag,
    input wire logic [31:0] in_data,
    input wire logic [31:0] mov_data,
    input wire logic [4:0] side_in,
    input wire logic side_en_in,
    output logic stall,
    output logic [31:0] out_data,
    output logic out_valid,
    output logic [4:0] side_out,
    output logic side_we,
    // tx fifo (read side)
    input wire logic tx_valid,
    input wire logic [31:0] tx_data,
    output logic tx_pop,
    // rx fifo (write side)
    input wire logic rx_full,
    output logic rx_push,
    output logic [31:0] rx_wdata
);
    import shift_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [31:0] osr;
        logic [31:0] isr;
        logic [5:0] osr_cnt;
        logic [5:0] isr_cnt;
        logic pull_en;
        logic push_en;
        logic out_right;
        logic in_right;
        logic [4:0] pull_th;
        logic [4:0] push_th;
        logic [31:0] prdata;
        logic pslverr;
        logic [31:0] out_data;
        logic out_valid;
        logic [4:0] side_data;
        logic side_we;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic [5:0] pull_lim;
    logic [5:0] push_lim;
    logic [5:0] nbits;
    logic [5:0] osr_sum;
    logic [5:0] isr_sum;
    logic [31:0] nmask;
    logic [63:0] osr_wide;
    logic [31:0] shifted_bits;
    logic [31:0] osr_after;
    logic [31:0] in_masked;
    logic [31:0] isr_after;
    logic osr_empty;
    logic run;
    logic setup;
    logic access_wr;
    logic mapped;

    // field value 0 stands for a full word
    function automatic logic [5:0] th_val(input logic [4:0] f);
        th_val = (f == 5'h00) ? cnt_max : {1'b0, f}; // [R15]
    endfunction

    // counts stop at a full word rather than wrap
    function automatic logic [5:0] sat_add(input logic [5:0] a, input logic [5:0] b);
        logic [6:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = (s > {1'b0, cnt_max}) ? cnt_max : s[5:0]; // [R1]
    endfunction

    // ************************************************************
    // shift datapath
    // ************************************************************
    always_comb begin
        pull_lim = th_val(state_r.pull_th);
        push_lim = th_val(state_r.push_th);
        nbits = (bit_count == 5'h00) ? cnt_max : {1'b0, bit_count};
        nmask = 32'((64'h1 << nbits) - 64'h1);
        osr_sum = sat_add(state_r.osr_cnt, nbits); // [R3]
        isr_sum = sat_add(state_r.isr_cnt, nbits); // [R4]
        if (state_r.out_right) begin
            osr_wide = {state_r.osr, 32'h0} >> nbits;
            shifted_bits = osr_wide[31:0] >> (6'd32 - nbits);
            osr_after = osr_wide[63:32];
        end else begin
            osr_wide = {32'h0, state_r.osr} << nbits;
            shifted_bits = osr_wide[63:32];
            osr_after = osr_wide[31:0];
        end
        in_masked = in_data & nmask;
        if (state_r.in_right) begin
            isr_after = 32'(({in_masked, state_r.isr}) >> nbits);
        end else if (nbits == cnt_max) begin
            isr_after = in_masked;
        end else begin
            isr_after = (state_r.isr << nbits) | in_masked;
        end
        osr_empty = state_r.osr_cnt >= pull_lim;
        run = sm_clk_en & instr_valid;
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        stall = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_wdata = 32'h0;
        state_nxt.out_valid = 1'b0;
        state_nxt.side_we = 1'b0;

        if (sm_restart_strobe) begin
            state_nxt.osr_cnt = osr_cnt_rst; // [R2]
            state_nxt.isr_cnt = isr_cnt_rst; // [R2]
        end else if (sm_clk_en) begin
            if (run) begin
                // side-set goes out whether or not the instruction stalls
                state_nxt.side_data = side_in; // [R18]
                state_nxt.side_we = side_en_in; // [R18]
                case (instr_op)
                    op_out: begin
                        if (state_r.pull_en && osr_empty) begin // [R9]
                            // loading and shifting an empty register together is too long a path
                            stall = 1'b1; // [R16] [R23]
                            if (tx_valid) begin
                                tx_pop = 1'b1; // [R20]
                                state_nxt.osr = tx_data;
                                state_nxt.osr_cnt = 6'h00; // [R5]
                            end
                        end else begin
                            state_nxt.out_data = shifted_bits & nmask;
                            state_nxt.out_valid = 1'b1;
                            state_nxt.osr = osr_after;
                            state_nxt.osr_cnt = osr_sum; // [R3]
                            if (out_to_isr) begin
                                state_nxt.isr = shifted_bits & nmask;
                                state_nxt.isr_cnt = nbits; // [R8]
                            end
                            // compare after the add so a 32-bit shift refills at once
                            if (state_r.pull_en && osr_sum >= pull_lim && tx_valid) begin // [R25] [R10]
                                tx_pop = 1'b1; // [R11] [R20]
                                state_nxt.osr = tx_data;
                                state_nxt.osr_cnt = 6'h00; // [R5]
                            end
                        end
                    end
                    op_in: begin
                        if (state_r.push_en && isr_sum >= push_lim) begin // [R9] [R25] [R10]
                            if (rx_full) begin
                                // nothing commits, the IN repeats next cycle
                                stall = 1'b1; // [R13]
                            end else begin
                                rx_push = 1'b1; // [R12] [R14] [R21]
                                rx_wdata = isr_after;
                                state_nxt.isr = 32'h0; // [R13]
                                state_nxt.isr_cnt = 6'h00; // [R6]
                            end
                        end else begin
                            state_nxt.isr = isr_after; // [R14]
                            state_nxt.isr_cnt = isr_sum; // [R4]
                        end
                    end
                    op_pull: begin
                        if ((state_r.pull_en || cond_flag) && !osr_empty) begin
                            // register still holds data: no-op, avoids racing the refill
                            stall = 1'b0; // [R17] [R24]
                        end else if (tx_valid) begin
                            tx_pop = 1'b1; // [R19]
                            state_nxt.osr = tx_data;
                            state_nxt.osr_cnt = 6'h00; // [R5]
                        end else if (block_flag) begin
                            stall = 1'b1; // [R24]
                        end else begin
                            state_nxt.osr = mov_data;
                            state_nxt.osr_cnt = 6'h00; // [R5]
                        end
                    end
                    op_push: begin
                        if (cond_flag && state_r.isr_cnt < push_lim) begin
                            stall = 1'b0;
                        end else if (!rx_full) begin
                            rx_push = 1'b1;
                            rx_wdata = state_r.isr;
                            state_nxt.isr = 32'h0;
                            state_nxt.isr_cnt = 6'h00; // [R6]
                        end else if (block_flag) begin
                            stall = 1'b1;
                        end else begin
                            stall = 1'b0;
                        end
                    end
                    op_mov_osr: begin
                        state_nxt.osr = mov_data;
                        state_nxt.osr_cnt = 6'h00; // [R7]
                    end
                    op_mov_isr: begin
                        state_nxt.isr = mov_data;
                        state_nxt.isr_cnt = 6'h00; // [R7]
                    end
                    default: begin
                        stall = 1'b0;
                    end
                endcase
            end
            // refill between OUTs, judged on the count after any clear above
            if (!(run && instr_op == op_out) && !tx_pop && state_r.pull_en
                && state_nxt.osr_cnt >= pull_lim && tx_valid) begin
                tx_pop = 1'b1; // [R22]
                state_nxt.osr = tx_data;
                state_nxt.osr_cnt = 6'h00; // [R5]
            end
        end

        // ********************************************************
        // apb slave: zero wait, read data captured in setup
        // ********************************************************
        setup = psel & ~penable;
        access_wr = psel & penable & pwrite;
        mapped = (paddr == cfg_off) || (paddr == status_off)
            || (paddr == osr_off) || (paddr == isr_off);
        if (setup) begin
            state_nxt.pslverr = ~mapped;
            state_nxt.prdata = 32'h0;
            if (!pwrite) begin
                case (paddr)
                    cfg_off: begin
                        state_nxt.prdata[pull_en_bit] = state_r.pull_en;
                        state_nxt.prdata[push_en_bit] = state_r.push_en;
                        state_nxt.prdata[out_right_bit] = state_r.out_right;
                        state_nxt.prdata[in_right_bit] = state_r.in_right;
                        state_nxt.prdata[pull_th_lsb +: th_width] = state_r.pull_th;
                        state_nxt.prdata[push_th_lsb +: th_width] = state_r.push_th;
                    end
                    status_off: begin
                        state_nxt.prdata[osr_cnt_lsb +: 6] = state_r.osr_cnt;
                        state_nxt.prdata[isr_cnt_lsb +: 6] = state_r.isr_cnt;
                        state_nxt.prdata[stall_bit] = stall;
                    end
                    osr_off: begin
                        state_nxt.prdata = state_r.osr;
                    end
                    isr_off: begin
                        state_nxt.prdata = state_r.isr;
                    end
                    default: begin
                        state_nxt.prdata = 32'h0;
                    end
                endcase
            end
        end
        // writes to read-only words are accepted and ignored
        if (access_wr && paddr == cfg_off) begin
            if (pstrb[0]) begin
                state_nxt.pull_en = pwdata[pull_en_bit]; // [R10]
                state_nxt.push_en = pwdata[push_en_bit]; // [R10]
                state_nxt.out_right = pwdata[out_right_bit];
                state_nxt.in_right = pwdata[in_right_bit];
            end
            if (pstrb[1]) begin
                state_nxt.pull_th = pwdata[pull_th_lsb +: th_width]; // [R15]
            end
            if (pstrb[2]) begin
                state_nxt.push_th = pwdata[push_th_lsb +: th_width]; // [R15]
            end
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r.osr <= 32'h0;
            state_r.isr <= 32'h0;
            state_r.osr_cnt <= osr_cnt_rst; // [R2]
            state_r.isr_cnt <= isr_cnt_rst; // [R2]
            state_r.pull_en <= cfg_bit_rst;
            state_r.push_en <= cfg_bit_rst;
            state_r.out_right <= shift_right_rst;
            state_r.in_right <= shift_right_rst;
            state_r.pull_th <= th_rst;
            state_r.push_th <= th_rst;
            state_r.prdata <= 32'h0;
            state_r.pslverr <= 1'b0;
            state_r.out_data <= 32'h0;
            state_r.out_valid <= 1'b0;
            state_r.side_data <= 5'h00;
            state_r.side_we <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pready = 1'b1;
    assign pslverr = state_r.pslverr & psel & penable;
    assign prdata = state_r.prdata;
    assign out_data = state_r.out_data;
    assign out_valid = state_r.out_valid;
    assign side_out = state_r.side_data;
    assign side_we = state_r.side_we;

endmodule

`default_nettype wire

/* File: bench/shift_checker_asserts.sv */
// port assertions for the shift count and autopush/autopull block
`timescale 1ns/1ps
`default_nettype none
module shift_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sm_clk_en,
    input wire logic sm_restart_strobe,
    input wire logic instr_valid,
    input wire shift_pkg::op_t instr_op,
    input wire logic [4:0] bit_count,
    input wire logic [31:0] in_data,
    input wire logic [4:0] side_in,
    input wire logic side_en_in,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [4:0] side_out,
    input wire logic side_we,
    input wire logic tx_valid,
    input wire logic tx_pop,
    input wire logic rx_full,
    input wire logic rx_push,
    input wire logic [31:0] rx_wdata
);
    import shift_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic run = sm_clk_en && instr_valid && !sm_restart_strobe;
    logic out_go_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_go_r <= 1'b0;
        end else begin
            out_go_r <= run && instr_op == op_out && !stall;
        end
    end
    AST_RX_FULL: assert property (rx_full |-> !rx_push)
        else $error("push into a full rx fifo");
    AST_POP_DATA: assert property (tx_pop |-> tx_valid && sm_clk_en)
        else $error("pop without tx data");
    AST_PUSH_CAUSE: assert property (rx_push |-> run && instr_op inside {op_in, op_push})
        else $error("push without in or push");
    AST_PUSH_WORD: assert property (
        run && instr_op == op_in && bit_count == 5'h00 && rx_push |-> rx_wdata == in_data)
        else $error("full word push carries wrong data");
    AST_STALL_RUN: assert property (stall |-> sm_clk_en && instr_valid)
        else $error("stall outside a run cycle");
    AST_SIDE: assert property (
        run && side_en_in |=> side_we && side_out == $past(side_in))
        else $error("side-set lost");
    AST_OUT_VALID: assert property (out_valid == out_go_r)
        else $error("out_valid does not follow an executed out");
    AST_REFILL_RUN: assert property (
        (run && instr_op == op_out && stall && tx_pop) ##1 (run && instr_op == op_out)
        |-> !stall)
        else $error("out still stalled after load");
    AST_RESTART: assert property (sm_restart_strobe |-> !tx_pop && !rx_push)
        else $error("fifo traffic during restart");
    AST_IDLE: assert property (!sm_clk_en |-> !tx_pop && !rx_push && !stall)
        else $error("activity without clock enable");
endmodule
`default_nettype wire

/* File: bench/fifo_model.sv */
// behavioural tx and rx fifos on the system side of the block
`timescale 1ns/1ps
`default_nettype none
module fifo_model (
    input wire logic pclk,
    input wire logic tx_pop,
    input wire logic rx_push,
    input wire logic [31:0] rx_wdata,
    output logic tx_valid,
    output logic [31:0] tx_data,
    output logic rx_full
);
    logic [31:0] mem [8];
    logic [3:0] rd_r = 4'h0;
    logic [3:0] wr_r = 4'h0;
    logic [31:0] junk_r = 32'h0f0f_3c3c;
    logic [31:0] rx_last_r = 32'h0;
    logic full_r = 1'b0;
    assign tx_valid = rd_r != wr_r;
    // an empty fifo shows a moving pattern, never the last word
    assign tx_data = tx_valid ? mem[rd_r[2:0]] : junk_r;
    assign rx_full = full_r;
    // filled between edges, as a dma would
    task automatic load(input logic [31:0] w);
        mem[wr_r[2:0]] = w;
        wr_r = wr_r + 4'h1;
    endtask
    always @(posedge pclk) begin
        junk_r <= ~junk_r;
        if (tx_pop && tx_valid) begin
            rd_r <= rd_r + 4'h1;
        end
        // a write into a full fifo is lost
        if (rx_push && !full_r) begin
            rx_last_r <= rx_wdata;
        end
    end
endmodule
`default_nettype wire

/* File: bench/shift_count_autopush_autopull_tb_top.sv */
// self-checking bench for the shift count and autopush/autopull block
`timescale 1ns/1ps
`default_nettype none
module shift_count_autopush_autopull_tb_top;
    import shift_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, in_data = 32'h1234_5678, mov_data = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic sm_clk_en = 1'b0, sm_restart_strobe = 1'b0, instr_valid = 1'b0;
    op_t instr_op = op_other;
    logic [4:0] bit_count = 5'h00, side_in = 5'h00;
    logic out_to_isr = 1'b0, cond_flag = 1'b0, block_flag = 1'b0, side_en_in = 1'b1;
    logic pready, pslverr, stall, out_valid, side_we, tx_valid, tx_pop, rx_full, rx_push;
    logic [31:0] prdata, out_data, tx_data, rx_wdata, rd, od;
    logic [4:0] side_out, so;
    logic st, pp, ph, ov, sw, er;
    int fails = 0, compares = 0, cyc = 0;
    typedef struct {
        op_t o;
        logic [4:0] n;
        logic x;
        logic [5:0] eo;
        logic [5:0] ei;
    } row_t;
    // operation, bit count, flag, then expected output and input counts
    row_t rows [9] = '{
        '{op_mov_osr, 5'h00, 1'b0, 6'h00, 6'h00},
        '{op_out, 5'h05, 1'b0, 6'h05, 6'h00},
        '{op_out, 5'h00, 1'b0, 6'h20, 6'h00},
        '{op_in, 5'h07, 1'b0, 6'h20, 6'h07},
        '{op_in, 5'h00, 1'b0, 6'h20, 6'h20},
        '{op_mov_isr, 5'h00, 1'b0, 6'h20, 6'h00},
        '{op_out, 5'h09, 1'b1, 6'h20, 6'h09},
        '{op_push, 5'h00, 1'b0, 6'h20, 6'h00},
        '{op_pull, 5'h00, 1'b0, 6'h00, 6'h00}
    };
    shift_count_autopush_autopull shift_count_autopush_autopull_i (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
        .pslverr, .prdata, .sm_clk_en, .sm_restart_strobe, .instr_valid, .instr_op,
        .bit_count, .out_to_isr, .cond_flag, .block_flag, .in_data, .mov_data, .side_in,
        .side_en_in, .stall, .out_data, .out_valid, .side_out, .side_we, .tx_valid,
        .tx_data, .tx_pop, .rx_full, .rx_push, .rx_wdata
    );
    fifo_model fifo_model_i (
        .pclk, .tx_pop, .rx_push, .rx_wdata, .tx_valid, .tx_data, .rx_full
    );
    always #12.5 pclk = ~pclk;
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // the instruction stays presented but idle while the bus is busy
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic ok;
        @(posedge pclk);
        sm_clk_en <= 1'b0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // the answer is taken at the rising edge that ends the access phase
        do begin
            @(posedge pclk);
            ok = pready;
            rd = prdata;
            er = pslverr;
        end while (ok !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic step(input op_t o, input logic [4:0] n, input logic v, input logic x);
        @(posedge pclk);
        sm_clk_en <= 1'b1;
        instr_valid <= v;
        instr_op <= o;
        bit_count <= n;
        side_in <= ~n;
        out_to_isr <= x;
        block_flag <= x;
        @(negedge pclk);
        st = stall;
        pp = tx_pop;
        ph = rx_push;
        ov = out_valid;
        od = out_data;
        sw = side_we;
        so = side_out;
    endtask
    // lets the presented instruction take one more edge, then parks the machine
    task automatic hold();
        @(posedge pclk);
        sm_clk_en <= 1'b0;
        @(negedge pclk);
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cfg_off, 32'h0);
        chk(rd === 32'h0000000c, "cfg reset value");
        apb(1'b0, status_off, 32'h0);
        chk(rd[5:0] === osr_cnt_rst && rd[13:8] === isr_cnt_rst, "reset counts");
        apb(1'b0, 12'h010, 32'h0);
        chk(er === 1'b1, "unmapped read not refused");
        foreach (rows[i]) begin
            step(rows[i].o, rows[i].n, 1'b1, rows[i].x);
            apb(1'b0, status_off, 32'h0);
            chk(rd[5:0] === rows[i].eo && rd[13:8] === rows[i].ei, "counts");
        end
        apb(1'b1, cfg_off, 32'h0000000f);
        @(posedge pclk);
        sm_restart_strobe <= 1'b1;
        sm_clk_en <= 1'b1;
        @(posedge pclk);
        sm_restart_strobe <= 1'b0;
        sm_clk_en <= 1'b0;
        apb(1'b0, status_off, 32'h0);
        chk(rd[5:0] === 6'h20 && rd[13:8] === 6'h00, "restart counts");
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b1 && pp === 1'b0, "out on empty");
        hold();
        fifo_model_i.load(32'h1111_2222);
        fifo_model_i.load(32'h3333_4444);
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b1 && pp === 1'b1, "load without shift");
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b0 && pp === 1'b1, "shift with refill");
        step(op_in, 5'h00, 1'b1, 1'b0);
        chk(ov === 1'b1 && od === 32'h1111_2222, "first word out");
        chk(st === 1'b0 && ph === 1'b1, "in pushes at once");
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(fifo_model_i.rx_last_r === 32'h1234_5678, "pushed word");
        chk(st === 1'b0 && pp === 1'b0, "last word without refill");
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b1, "drained out");
        hold();
        fifo_model_i.load(32'h5555_6666);
        step(op_other, 5'h00, 1'b0, 1'b0);
        chk(pp === 1'b1, "refill between outs");
        fifo_model_i.full_r = 1'b1;
        step(op_in, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b1 && ph === 1'b0, "full rx");
        hold();
        chk(side_we === 1'b1 && side_out === 5'h1f, "side-set on stall");
        fifo_model_i.full_r = 1'b0;
        step(op_in, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b0 && ph === 1'b1, "in retried");
        fifo_model_i.load(32'h7777_8888);
        step(op_pull, 5'h00, 1'b1, 1'b1);
        chk(st === 1'b0 && pp === 1'b0, "pull on full register");
        apb(1'b1, cfg_off, 32'h0004000e);
        step(op_in, 5'h03, 1'b1, 1'b0);
        chk(ph === 1'b0, "below push threshold");
        step(op_in, 5'h01, 1'b1, 1'b0);
        chk(ph === 1'b1, "push at threshold 4");
        step(op_out, 5'h00, 1'b1, 1'b0);
        chk(pp === 1'b0 && st === 1'b0, "autopull disabled");
        apb(1'b0, status_off, 32'h0);
        chk(rd[5:0] === 6'h20 && rd[13:8] === 6'h00, "final counts");
        // pull-if-empty with autopull off: the threshold alone decides emptiness
        cond_flag <= 1'b1;
        step(op_mov_osr, 5'h00, 1'b1, 1'b0);
        step(op_pull, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b0 && pp === 1'b0, "pull ifempty on full register");
        step(op_out, 5'h00, 1'b1, 1'b0);
        step(op_pull, 5'h00, 1'b1, 1'b0);
        chk(st === 1'b0 && pp === 1'b1, "pull ifempty on empty register");
        complete_run();
    end
endmodule
bind shift_count_autopush_autopull shift_checker shift_checker_i (
    .pclk, .presetn, .sm_clk_en, .sm_restart_strobe, .instr_valid, .instr_op,
    .bit_count, .in_data, .side_in, .side_en_in, .stall, .out_valid, .side_out,
    .side_we, .tx_valid, .tx_pop, .rx_full, .rx_push, .rx_wdata
);
`default_nettype wire
